/* rtl/power_sign_pkg.sv */
package power_sign_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int ADDR_W = 20;
  localparam int DATA_W = 32;
  localparam int PWR_W_DEF = 24;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Register indices; the byte address is four times the index
  localparam logic [15:0] IDX_SIGN_STATUS = 16'he617;
  localparam logic [15:0] IDX_ACCUM_MODE = 16'he700;
  localparam logic [15:0] IDX_COMP_MODE = 16'he701;
  localparam logic [15:0] IDX_PULSE_MODE = 16'he702;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'he703;
  localparam logic [15:0] IDX_IRQ_CLEAR = 16'he704;
  localparam logic [15:0] IDX_IRQ_ENABLE = 16'he705;

  // ==========================================================================
  // Field positions
  localparam int POS_ACTIVE_SIGN = 0;
  localparam int POS_PATH1_SUM = 3;
  localparam int POS_REACTIVE_SIGN = 4;
  localparam int POS_PATH2_SUM = 7;
  localparam int POS_PATH3_SUM = 8;
  localparam int SIGN_USED_W = 9;
  localparam int SIGN_REG_W = 16;
  localparam int POS_ACTIVE_SRC = 6;
  localparam int POS_REACTIVE_SRC = 7;
  localparam int PATH_FIELD_W = 3;
  localparam int PATH_FIELD_LSB1 = 0;
  localparam int PATH_FIELD_LSB2 = 3;
  localparam int PATH_FIELD_LSB3 = 6;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] RST_SIGN_STATUS = 16'h0000;
  localparam logic [15:0] RST_ACCUM_MODE = 16'h0000;
  localparam logic [15:0] RST_COMP_MODE = 16'h01ff;
  localparam logic [15:0] RST_PULSE_MODE = 16'h0088;
  localparam logic [8:0] RST_IRQ = 9'h000;

  // ==========================================================================
  // Power quantity carried by a pulse-output path
  typedef enum logic [2:0] {
    TYPE_ACTIVE_TOTAL = 3'h0,
    TYPE_REACTIVE_TOTAL = 3'h1,
    TYPE_APPARENT = 3'h2,
    TYPE_ACTIVE_FUND = 3'h3,
    TYPE_REACTIVE_FUND = 3'h4
  } power_type_t;

endpackage

/* rtl/sign_source_reg.sv */
`timescale 1ns/1ps
module sign_source_reg
  import power_sign_pkg::*;
#(
  parameter int PWR_W = PWR_W_DEF
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [PWR_W-1:0] TOTAL,
  input wire logic [PWR_W-1:0] FUNDAMENTAL,
  input wire logic USE_FUNDAMENTAL,
  input wire logic UPDATE,
  input wire logic ENABLE,
  output logic NEGATIVE
);

  // Selected figure; zero counts as positive since only the sign bit is seen
  wire logic [PWR_W-1:0] chosen = USE_FUNDAMENTAL ? FUNDAMENTAL : TOTAL;
  wire logic next_negative = ENABLE & chosen[PWR_W-1];

  // Refreshed only on a new result; a disabled quantity stays at zero
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      NEGATIVE <= 1'b0;
    end else if (!ENABLE) begin
      NEGATIVE <= 1'b0;
    end else if (UPDATE) begin
      NEGATIVE <= next_negative;
    end
  end

endmodule // sign_source_reg

/* rtl/path_sum_sign.sv */
`timescale 1ns/1ps
module path_sum_sign
  import power_sign_pkg::*;
#(
  parameter int PWR_W = PWR_W_DEF
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [3*PWR_W-1:0] ACTIVE_TOTAL,
  input wire logic [3*PWR_W-1:0] ACTIVE_FUND,
  input wire logic [3*PWR_W-1:0] REACTIVE_TOTAL,
  input wire logic [3*PWR_W-1:0] REACTIVE_FUND,
  input wire logic [3*PWR_W-1:0] APPARENT,
  input wire logic [2:0] TERM_SELECT,
  input wire logic [2:0] TYPE_SELECT,
  input wire logic ACTIVE_UPDATE,
  input wire logic REACTIVE_UPDATE,
  input wire logic APPARENT_UPDATE,
  output logic NEGATIVE
);

  logic [3*PWR_W-1:0] source;
  logic update;
  wire logic [PWR_W+1:0] term [3];
  wire logic [PWR_W+1:0] sum = term[0] + term[1] + term[2];

  // Unknown type codes fall back to total active power
  always_comb begin
    case (power_type_t'(TYPE_SELECT))
      TYPE_REACTIVE_TOTAL: begin
        source = REACTIVE_TOTAL;
        update = REACTIVE_UPDATE;
      end
      TYPE_APPARENT: begin
        source = APPARENT;
        update = APPARENT_UPDATE;
      end
      TYPE_ACTIVE_FUND: begin
        source = ACTIVE_FUND;
        update = ACTIVE_UPDATE;
      end
      TYPE_REACTIVE_FUND: begin
        source = REACTIVE_FUND;
        update = REACTIVE_UPDATE;
      end
      default: begin
        source = ACTIVE_TOTAL;
        update = ACTIVE_UPDATE;
      end
    endcase
  end

  // Two guard bits keep a three-term sum from wrapping
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_term
      assign term[p] = TERM_SELECT[p] ?
        {{2{source[p*PWR_W+PWR_W-1]}}, source[p*PWR_W +: PWR_W]} : '0;
    end
  endgenerate

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      NEGATIVE <= 1'b0;
    end else if (update) begin
      NEGATIVE <= sum[PWR_W+1];
    end
  end

endmodule // path_sum_sign

/* rtl/power_sign_status.sv */
// Operation
// (RULE1) Bits 0..2 show phase A, B, C active power negative (1) or positive (0).
// (RULE2) Accumulation-mode bit 6 picks total or fundamental active power for those bits.
// (RULE3) Bits 4..6 show phase A, B, C reactive power negative (1) or positive (0).
// (RULE4) Accumulation-mode bit 7 picks total or fundamental reactive power for those bits.
// (RULE5) Without reactive measurement the three reactive sign bits stay zero.
// (RULE6) Bit 3 shows the first pulse path phase sum negative; fields at bits 2:0.
// (RULE7) Bit 7 shows the second pulse path phase sum negative; fields at bits 5:3.
// (RULE8) Bit 8 shows the third pulse path phase sum negative; fields at bits 8:6.
// (RULE9) Upper bits 15..9 of the sign register always read zero.
// (RULE10) Sign register is read-only; bits refresh on each new power result.
`timescale 1ns/1ps
module power_sign_status
  import power_sign_pkg::*;
#(
  parameter int PWR_W = PWR_W_DEF,
  parameter bit HAS_REACTIVE = 1'b1
) (
  input wire logic CLK,
  input wire logic RST_B,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [DATA_W-1:0] S_AXI_WDATA,
  input wire logic [DATA_W/8-1:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Per-phase results of the power computation, phase A in the low slice
  input wire logic [3*PWR_W-1:0] ACTIVE_TOTAL,
  input wire logic [3*PWR_W-1:0] ACTIVE_FUNDAMENTAL,
  input wire logic [3*PWR_W-1:0] REACTIVE_TOTAL,
  input wire logic [3*PWR_W-1:0] REACTIVE_FUNDAMENTAL,
  input wire logic [3*PWR_W-1:0] APPARENT,
  input wire logic ACTIVE_READY,
  input wire logic REACTIVE_READY,
  input wire logic APPARENT_READY,
  // Level interrupt
  output logic IRQ
);

  // ==========================================================================
  // Byte addresses of the register map
  localparam logic [ADDR_W-1:0] ADDR_SIGN = {2'h0, IDX_SIGN_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_ACCUM = {2'h0, IDX_ACCUM_MODE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_COMP = {2'h0, IDX_COMP_MODE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_PULSE = {2'h0, IDX_PULSE_MODE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ST = {2'h0, IDX_IRQ_STATUS, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR = {2'h0, IDX_IRQ_CLEAR, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_EN = {2'h0, IDX_IRQ_ENABLE, 2'h0};

  // ==========================================================================
  // Write channel state
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W/8-1:0] wr_strb;

  // Software registers
  logic [15:0] accumulation_mode_register;
  logic [15:0] computation_mode_register;
  logic [15:0] pulse_output_mode_register;
  logic [SIGN_USED_W-1:0] irq_status;
  logic [SIGN_USED_W-1:0] irq_enable;
  logic [SIGN_USED_W-1:0] sign_prev;

  // Sign bits, each held in a flop of its own instance
  wire logic phase_a_active_negative;
  wire logic phase_b_active_negative;
  wire logic phase_c_active_negative;
  wire logic phase_a_reactive_negative;
  wire logic phase_b_reactive_negative;
  wire logic phase_c_reactive_negative;
  wire logic pulse_path1_sum_negative;
  wire logic pulse_path2_sum_negative;
  wire logic pulse_path3_sum_negative;
  wire logic [2:0] active_negative;
  wire logic [2:0] reactive_negative;
  wire logic [2:0] path_negative;

  // ==========================================================================
  // Handshakes
  wire logic aw_take = S_AXI_AWVALID & S_AXI_AWREADY;
  wire logic w_take = S_AXI_WVALID & S_AXI_WREADY;
  wire logic wr_fire = aw_held & w_held & ~S_AXI_BVALID;
  wire logic ar_take = S_AXI_ARVALID & S_AXI_ARREADY;
  wire logic b_done = S_AXI_BVALID & S_AXI_BREADY;
  wire logic r_done = S_AXI_RVALID & S_AXI_RREADY;
  wire logic next_aw_held = (aw_held | aw_take) & ~wr_fire;
  wire logic next_w_held = (w_held | w_take) & ~wr_fire;

  // ==========================================================================
  // Write decode; a write to the sign register hits but changes nothing
  wire logic wr_hit_sign = wr_addr == ADDR_SIGN;
  wire logic wr_hit_accum = wr_addr == ADDR_ACCUM;
  wire logic wr_hit_comp = wr_addr == ADDR_COMP;
  wire logic wr_hit_pulse = wr_addr == ADDR_PULSE;
  wire logic wr_hit_irq_st = wr_addr == ADDR_IRQ_ST;
  wire logic wr_hit_irq_clr = wr_addr == ADDR_IRQ_CLR;
  wire logic wr_hit_irq_en = wr_addr == ADDR_IRQ_EN;
  wire logic wr_mapped = wr_hit_sign | wr_hit_accum | wr_hit_comp | wr_hit_pulse |
                         wr_hit_irq_st | wr_hit_irq_clr | wr_hit_irq_en;
  wire logic [15:0] lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  wire logic [15:0] wr_low = wr_data[15:0];

  // Byte-lane merge for the 16-bit read/write registers
  wire logic [15:0] next_accum = (accumulation_mode_register & ~lane_mask) |
                                 (wr_low & lane_mask);
  wire logic [15:0] next_comp = (computation_mode_register & ~lane_mask) |
                                (wr_low & lane_mask);
  wire logic [15:0] next_pulse = (pulse_output_mode_register & ~lane_mask) |
                                 (wr_low & lane_mask);
  wire logic [SIGN_USED_W-1:0] next_irq_enable =
    (irq_enable & ~lane_mask[SIGN_USED_W-1:0]) | (wr_low[SIGN_USED_W-1:0] &
    lane_mask[SIGN_USED_W-1:0]);

  // ==========================================================================
  // Write address and data are taken in either order
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      S_AXI_AWREADY <= ~next_aw_held;
      S_AXI_WREADY <= ~next_w_held;
      if (aw_take) begin
        wr_addr <= {S_AXI_AWADDR[ADDR_W-1:2], 2'h0};
      end
      if (w_take) begin
        wr_data <= S_AXI_WDATA;
        wr_strb <= S_AXI_WSTRB;
      end
    end
  end

  // Write response; the next write waits until this one is accepted
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= RESP_OKAY;
    end else if (wr_fire) begin
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (b_done) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // ==========================================================================
  // Mode registers steer the sign sources and the pulse paths
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      accumulation_mode_register <= RST_ACCUM_MODE;
      computation_mode_register <= RST_COMP_MODE;
      pulse_output_mode_register <= RST_PULSE_MODE;
      irq_enable <= RST_IRQ;
    end else if (wr_fire) begin
      if (wr_hit_accum) begin
        accumulation_mode_register <= next_accum;
      end
      if (wr_hit_comp) begin
        computation_mode_register <= next_comp;
      end
      if (wr_hit_pulse) begin
        pulse_output_mode_register <= next_pulse;
      end
      if (wr_hit_irq_en) begin
        irq_enable <= next_irq_enable;
      end
    end
  end

  // ==========================================================================
  // Per-phase active and reactive sign bits
  wire logic active_src = accumulation_mode_register[POS_ACTIVE_SRC]; // RULE2
  wire logic reactive_src = accumulation_mode_register[POS_REACTIVE_SRC]; // RULE4

  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_phase
      sign_source_reg #(
        .PWR_W(PWR_W)
      ) u_active (
        .CLK(CLK),
        .RST_B(RST_B),
        .TOTAL(ACTIVE_TOTAL[p*PWR_W +: PWR_W]),
        .FUNDAMENTAL(ACTIVE_FUNDAMENTAL[p*PWR_W +: PWR_W]),
        .USE_FUNDAMENTAL(active_src), // RULE2
        .UPDATE(ACTIVE_READY), // RULE10
        .ENABLE(1'b1),
        .NEGATIVE(active_negative[p]) // RULE1
      );
      // A part without reactive measurement forces these to zero
      sign_source_reg #(
        .PWR_W(PWR_W)
      ) u_reactive (
        .CLK(CLK),
        .RST_B(RST_B),
        .TOTAL(REACTIVE_TOTAL[p*PWR_W +: PWR_W]),
        .FUNDAMENTAL(REACTIVE_FUNDAMENTAL[p*PWR_W +: PWR_W]),
        .USE_FUNDAMENTAL(reactive_src), // RULE4
        .UPDATE(REACTIVE_READY), // RULE10
        .ENABLE(HAS_REACTIVE), // RULE5
        .NEGATIVE(reactive_negative[p]) // RULE3
      );
    end
  endgenerate

  // ==========================================================================
  // Pulse-output path sums; term and type fields share bit positions
  wire logic [2:0] path1_phase_term_select =
    computation_mode_register[PATH_FIELD_LSB1 +: PATH_FIELD_W]; // RULE6
  wire logic [2:0] path2_phase_term_select =
    computation_mode_register[PATH_FIELD_LSB2 +: PATH_FIELD_W]; // RULE7
  wire logic [2:0] path3_phase_term_select =
    computation_mode_register[PATH_FIELD_LSB3 +: PATH_FIELD_W]; // RULE8
  wire logic [2:0] path1_power_type_select =
    pulse_output_mode_register[PATH_FIELD_LSB1 +: PATH_FIELD_W]; // RULE6
  wire logic [2:0] path2_power_type_select =
    pulse_output_mode_register[PATH_FIELD_LSB2 +: PATH_FIELD_W]; // RULE7
  wire logic [2:0] path3_power_type_select =
    pulse_output_mode_register[PATH_FIELD_LSB3 +: PATH_FIELD_W]; // RULE8
  wire logic [8:0] term_selects = {path3_phase_term_select, path2_phase_term_select,
                                   path1_phase_term_select};
  wire logic [8:0] type_selects = {path3_power_type_select, path2_power_type_select,
                                   path1_power_type_select};
  // Reactive terms read as zero when the part has no reactive measurement
  wire logic [3*PWR_W-1:0] reactive_total_in = HAS_REACTIVE ? REACTIVE_TOTAL : '0;
  wire logic [3*PWR_W-1:0] reactive_fund_in = HAS_REACTIVE ? REACTIVE_FUNDAMENTAL : '0;

  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_path
      path_sum_sign #(
        .PWR_W(PWR_W)
      ) u_sum (
        .CLK(CLK),
        .RST_B(RST_B),
        .ACTIVE_TOTAL(ACTIVE_TOTAL),
        .ACTIVE_FUND(ACTIVE_FUNDAMENTAL),
        .REACTIVE_TOTAL(reactive_total_in),
        .REACTIVE_FUND(reactive_fund_in),
        .APPARENT(APPARENT),
        .TERM_SELECT(term_selects[c*PATH_FIELD_W +: PATH_FIELD_W]),
        .TYPE_SELECT(type_selects[c*PATH_FIELD_W +: PATH_FIELD_W]),
        .ACTIVE_UPDATE(ACTIVE_READY), // RULE10
        .REACTIVE_UPDATE(REACTIVE_READY),
        .APPARENT_UPDATE(APPARENT_READY),
        .NEGATIVE(path_negative[c])
      );
    end
  endgenerate

  // ==========================================================================
  // Assemble the sign register; upper bits are tied low
  assign phase_a_active_negative = active_negative[0];
  assign phase_b_active_negative = active_negative[1];
  assign phase_c_active_negative = active_negative[2];
  assign phase_a_reactive_negative = reactive_negative[0];
  assign phase_b_reactive_negative = reactive_negative[1];
  assign phase_c_reactive_negative = reactive_negative[2];
  assign pulse_path1_sum_negative = path_negative[0];
  assign pulse_path2_sum_negative = path_negative[1];
  assign pulse_path3_sum_negative = path_negative[2];

  wire logic [SIGN_USED_W-1:0] sign_bits = {
    pulse_path3_sum_negative, // RULE8
    pulse_path2_sum_negative, // RULE7
    phase_c_reactive_negative,
    phase_b_reactive_negative,
    phase_a_reactive_negative, // RULE3
    pulse_path1_sum_negative, // RULE6
    phase_c_active_negative,
    phase_b_active_negative,
    phase_a_active_negative // RULE1
  };
  wire logic [SIGN_REG_W-1:0] power_sign_status =
    {{(SIGN_REG_W-SIGN_USED_W){1'b0}}, sign_bits}; // RULE9

  // ==========================================================================
  // Interrupts: any sign flip is an event; a new event beats a clear
  wire logic [SIGN_USED_W-1:0] sign_event = sign_bits ^ sign_prev;
  wire logic [SIGN_USED_W-1:0] irq_clear =
    (wr_fire & wr_hit_irq_clr) ? (wr_low[SIGN_USED_W-1:0] &
    lane_mask[SIGN_USED_W-1:0]) : '0;
  wire logic [SIGN_USED_W-1:0] next_irq_status = (irq_status & ~irq_clear) | sign_event;

  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      sign_prev <= RST_SIGN_STATUS[SIGN_USED_W-1:0];
      irq_status <= RST_IRQ;
      IRQ <= 1'b0;
    end else begin
      sign_prev <= sign_bits;
      irq_status <= next_irq_status;
      IRQ <= |(next_irq_status & irq_enable);
    end
  end

  // ==========================================================================
  // Read decode; the clear register reads as zero
  wire logic [ADDR_W-1:0] rd_addr = {S_AXI_ARADDR[ADDR_W-1:2], 2'h0};
  wire logic rd_hit_sign = rd_addr == ADDR_SIGN;
  wire logic rd_hit_accum = rd_addr == ADDR_ACCUM;
  wire logic rd_hit_comp = rd_addr == ADDR_COMP;
  wire logic rd_hit_pulse = rd_addr == ADDR_PULSE;
  wire logic rd_hit_irq_st = rd_addr == ADDR_IRQ_ST;
  wire logic rd_hit_irq_clr = rd_addr == ADDR_IRQ_CLR;
  wire logic rd_hit_irq_en = rd_addr == ADDR_IRQ_EN;
  wire logic rd_mapped = rd_hit_sign | rd_hit_accum | rd_hit_comp | rd_hit_pulse |
                         rd_hit_irq_st | rd_hit_irq_clr | rd_hit_irq_en;
  wire logic [15:0] rd_value =
    rd_hit_sign ? power_sign_status :
    rd_hit_accum ? accumulation_mode_register :
    rd_hit_comp ? computation_mode_register :
    rd_hit_pulse ? pulse_output_mode_register :
    rd_hit_irq_st ? {{(16-SIGN_USED_W){1'b0}}, irq_status} :
    rd_hit_irq_en ? {{(16-SIGN_USED_W){1'b0}}, irq_enable} : 16'h0000;

  // One read at a time; address is refused while data waits
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= '0;
      S_AXI_RRESP <= RESP_OKAY;
    end else if (ar_take) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= {16'h0000, rd_value};
      S_AXI_RRESP <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (r_done) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end else begin
      S_AXI_ARREADY <= ~S_AXI_RVALID;
    end
  end

endmodule // power_sign_status

/* tb/power_sign_chk.sv */
`timescale 1ns/1ps
module power_sign_chk
  import power_sign_pkg::*;
#(
  parameter bit HAS_REACTIVE = 1'b1
) (
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic S_AXI_AWVALID,
  input wire logic S_AXI_AWREADY,
  input wire logic S_AXI_WVALID,
  input wire logic S_AXI_WREADY,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [DATA_W-1:0] S_AXI_RDATA
);
  // ==========================================================================
  // Read in flight targets the sign register
  logic rd_sign;
  always_ff @(posedge CLK) begin
    if (!RST_B) rd_sign <= 1'b0;
    else if (S_AXI_ARVALID && S_AXI_ARREADY) rd_sign <= S_AXI_ARADDR[19:2] == {2'h0, IDX_SIGN_STATUS};
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // ==========================================================================
  // A write taken with no response pending is answered two cycles later
  sequence s_wr_take; S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && !S_AXI_BVALID; endsequence
  sequence s_b_answer; !S_AXI_BVALID ##1 S_AXI_BVALID; endsequence
  property p_wr_answer; s_wr_take |=> s_b_answer; endproperty
  property p_b_hold; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
  property p_rd_answer; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY; endproperty
  property p_rd_hold; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
  property p_r_release; S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID && S_AXI_ARREADY; endproperty
  property p_upper_zero; S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000; endproperty
  property p_sign_rsvd; S_AXI_RVALID && rd_sign |-> S_AXI_RDATA[15:9] == 7'h00; endproperty
  property p_no_react; S_AXI_RVALID && rd_sign && !HAS_REACTIVE |-> S_AXI_RDATA[6:4] == 3'h0; endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("late write response");
  a_b_hold: assert property (p_b_hold)
    else $error("write response not held");
  a_rd_answer: assert property (p_rd_answer)
    else $error("late read answer");
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data not held");
  a_r_release: assert property (p_r_release)
    else $error("read channel not released");
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits set");
  a_sign_rsvd: assert property (p_sign_rsvd)
    else $error("reserved sign bits set");
  a_no_react: assert property (p_no_react)
    else $error("reactive sign bits set");
endmodule // power_sign_chk

bind power_sign_status power_sign_chk #(.HAS_REACTIVE(HAS_REACTIVE)) u_chk (.*);

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import power_sign_pkg::*;
  logic CLK, RST_B, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID;
  logic S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, IRQ;
  logic ACTIVE_READY, REACTIVE_READY, APPARENT_READY;
  logic [ADDR_W-1:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [2:0] S_AXI_AWPROT, S_AXI_ARPROT;
  logic [DATA_W-1:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic [71:0] ACTIVE_TOTAL, ACTIVE_FUNDAMENTAL, REACTIVE_TOTAL, REACTIVE_FUNDAMENTAL, APPARENT;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic [15:0] accm, comp, pulm, sgn;
  logic [8:0] ist, en;
  int n_errors, checked;
  power_sign_status dut (.*);
  // ==========================================================================
  // Clock and verdict
  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end
  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 60) begin
      n_errors++;
      end_of_test();
    end
  endtask
  // Oldest expectation meets each bus answer
  always @(posedge CLK) begin
    if (S_AXI_RVALID && S_AXI_RREADY) chk("rd", {S_AXI_RRESP, S_AXI_RDATA}, rq.pop_front());
    if (S_AXI_BVALID && S_AXI_BREADY) chk("bresp", 34'(S_AXI_BRESP), 34'(bq.pop_front()));
  end
  // ==========================================================================
  // Bus tasks; answer ready may start late to test holding
  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    int n;
    bq.push_back(r);
    S_AXI_AWADDR <= {2'h0, idx, 2'h0};
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'($urandom);
    for (n = 0; n < 60; n++) begin
      @(posedge CLK);
      if (S_AXI_BVALID && S_AXI_BREADY) break;
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      S_AXI_BREADY <= 1'b1;
    end
    S_AXI_BREADY <= 1'b0;
    tmo(n);
    @(posedge CLK);
  endtask
  task automatic rd(input logic [15:0] idx, input logic [15:0] v);
    int n;
    rq.push_back({RESP_OKAY, 32'(v)});
    S_AXI_ARADDR <= {2'h0, idx, 2'h0};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'($urandom);
    for (n = 0; n < 60; n++) begin
      @(posedge CLK);
      if (S_AXI_RVALID && S_AXI_RREADY) break;
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      S_AXI_RREADY <= 1'b1;
    end
    S_AXI_RREADY <= 1'b0;
    tmo(n);
    @(posedge CLK);
  endtask
  // ==========================================================================
  // Expected sign word from powers and modes
  function automatic logic [15:0] f_sign();
    logic [15:0] s;
    logic [71:0] v;
    logic [25:0] acc;
    s = 16'h0000;
    for (int k = 0; k < 3; k++) begin
      v = accm[6] ? ACTIVE_FUNDAMENTAL : ACTIVE_TOTAL;
      s[k] = v[24*k+23];
      v = accm[7] ? REACTIVE_FUNDAMENTAL : REACTIVE_TOTAL;
      s[k+4] = v[24*k+23];
    end
    for (int p = 0; p < 3; p++) begin
      case (pulm[3*p+:3])
        3'h1: v = REACTIVE_TOTAL;
        3'h2: v = APPARENT;
        3'h3: v = ACTIVE_FUNDAMENTAL;
        3'h4: v = REACTIVE_FUNDAMENTAL;
        default: v = ACTIVE_TOTAL;
      endcase
      acc = 26'h0;
      for (int k = 0; k < 3; k++) begin
        if (comp[3*p+k]) acc = acc + {{2{v[24*k+23]}}, v[24*k+:24]};
      end
      s[p == 0 ? 3 : p + 6] = acc[25];
    end
    return s;
  endfunction
  function automatic logic [71:0] r72();
    return 72'({$urandom, $urandom, $urandom});
  endfunction
  // New powers, strobed or not, then the interrupt level
  task automatic pw(input logic upd);
    logic [15:0] ns;
    ACTIVE_TOTAL <= r72();
    ACTIVE_FUNDAMENTAL <= r72();
    REACTIVE_TOTAL <= r72();
    REACTIVE_FUNDAMENTAL <= r72();
    APPARENT <= r72();
    {ACTIVE_READY, REACTIVE_READY, APPARENT_READY} <= {3{upd}};
    @(posedge CLK);
    ns = upd ? f_sign() : sgn;
    ist = ist | 9'(ns ^ sgn);
    sgn = ns;
    {ACTIVE_READY, REACTIVE_READY, APPARENT_READY} <= 3'h0;
    repeat (2) @(posedge CLK);
    chk("irq", 34'(IRQ), 34'(|(ist & en)));
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(75));
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY, RST_B} = 6'h00;
    {ACTIVE_READY, REACTIVE_READY, APPARENT_READY, S_AXI_AWPROT, S_AXI_ARPROT} = 9'h000;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 72'h0;
    S_AXI_WSTRB = 4'hf;
    {ACTIVE_TOTAL, ACTIVE_FUNDAMENTAL, REACTIVE_TOTAL, REACTIVE_FUNDAMENTAL, APPARENT} = 360'h0;
    {accm, comp, pulm, sgn, ist, en} = {16'h0000, 16'h01ff, 16'h0088, 16'h0000, 18'h0};
    repeat (3) @(posedge CLK);
    RST_B <= 1'b1;
    @(posedge CLK);
    rd(IDX_SIGN_STATUS, 16'h0000);
    rd(IDX_ACCUM_MODE, accm);
    rd(IDX_COMP_MODE, comp);
    rd(IDX_PULSE_MODE, pulm);
    wr(IDX_SIGN_STATUS, 32'hffff);
    wr(16'h0123, 32'h1, RESP_SLVERR);
    rd(IDX_SIGN_STATUS, 16'h0000);
    for (int i = 0; i < 40; i++) begin
      accm = 16'($urandom);
      comp = 16'($urandom);
      pulm = 16'($urandom);
      wr(IDX_ACCUM_MODE, 32'(accm));
      wr(IDX_COMP_MODE, 32'(comp));
      wr(IDX_PULSE_MODE, 32'(pulm));
      pw(1'b1);
      rd(IDX_SIGN_STATUS, sgn);
      rd(IDX_IRQ_STATUS, 16'(ist));
    end
    // Unstrobed powers: sign word holds
    pw(1'b0);
    rd(IDX_SIGN_STATUS, sgn);
    // Interrupt: clear, enable, raise, mask, unmask, clear
    wr(IDX_IRQ_CLEAR, 32'h1ff);
    ist = 9'h0;
    for (int i = 0; i < 3; i++) begin
      en = i == 1 ? 9'h0 : 9'h1ff;
      wr(IDX_IRQ_ENABLE, 32'(en));
      pw(i == 0);
    end
    rd(IDX_IRQ_STATUS, 16'(ist));
    wr(IDX_IRQ_CLEAR, 32'h1ff);
    ist = 9'h0;
    pw(1'b0);
    rd(IDX_IRQ_CLEAR, 16'h0000);
    end_of_test();
  end
endmodule // tb
